// File: rtl/gpcsc_consts.vh
// Purpose: constants for the gpib controller status/control block
// Assumes: 20 MHz hclk, AHB-Lite register access
// Notes:   byte offsets of word registers
`ifndef GPCSC_CONSTS_VH
`define GPCSC_CONSTS_VH
`define GPCSC_CLK_HZ        20000000
// register byte offsets
`define GPCSC_A_CMD         8'h00
`define GPCSC_A_CFG         8'h04
`define GPCSC_A_TMO         8'h08
`define GPCSC_A_STB         8'h0C
`define GPCSC_A_SPADDR      8'h10
`define GPCSC_A_SPRESP      8'h14
`define GPCSC_A_MASK        8'h18
`define GPCSC_A_STATUS      8'h1C
`define GPCSC_A_ERR         8'h20
// command bits (write 1 pulses)
`define GPCSC_C_IFC         0
`define GPCSC_C_POLLED_BY_CONTROLLER       1
`define GPCSC_C_WAIT        2
`define GPCSC_C_STOP        3
`define GPCSC_C_XFER_SYNC   4
`define GPCSC_C_XFER_ASYNC  5
`define GPCSC_C_DONE        6
`define GPCSC_C_CLRERR      7
// config bits
`define GPCSC_F_SYSCTL      0
`define GPCSC_F_REN         1
`define GPCSC_F_AUTOPOLL    2
`define GPCSC_F_BOARD       3
// status word bits
`define GPCSC_S_ERR         15
`define GPCSC_S_TIMEOUT_FLAG        14
`define GPCSC_S_END         13
`define GPCSC_S_SRQ_LINE_SEEN        12
`define GPCSC_S_RQS         11
`define GPCSC_S_POLLED_BY_CONTROLLER       10
`define GPCSC_S_EVENT       9
`define GPCSC_S_IO_COMPLETE        8
`define GPCSC_S_LOC         7
`define GPCSC_S_REM         6
`define GPCSC_S_CIC         5
`define GPCSC_S_ATN         4
`define GPCSC_S_TACS        3
`define GPCSC_S_LACS        2
`define GPCSC_S_DTAS        1
`define GPCSC_S_DCAS        0
`define GPCSC_RQS_BIT       6
`define GPCSC_DEV_MASK      16'h6900
`define GPCSC_BRD_MASK      16'hF7FF
// error codes
`define GPCSC_E_NONE        4'h0
`define GPCSC_E_ABORT       4'h6
`define GPCSC_E_NOTSYSC     4'h5
// timing: ifc least 100 ns, timeout tick 10 us
`define GPCSC_IFC_NS        100
`define GPCSC_IFC_CYC       ((`GPCSC_IFC_NS * 20 + 999) / 1000)
`define GPCSC_TICK_US       10
`define GPCSC_TICK_CYC      (`GPCSC_TICK_US * 20)
`endif

// File: rtl/gpcsc_top.v
// Purpose: gpib controller status/control core behind an AHB-Lite slave
// Assumes: single clock hclk at 20 MHz, gpib lines resolved outside
// Notes:   data transfers themselves live elsewhere; this core times them
// Function
// RULE1: poll response with bit 6 set means instrument requests service
// RULE2: auto polling on: repeat poll of same address returns stored byte
// RULE3: as device, host writes status byte and service request is raised
// RULE4: system controller interface clear drives ifc at least 100 ns
// RULE5: interface clear reinitialises, takes charge and asserts atn
// RULE6: remote enable value 1 asserts ren, 0 releases it; code drives ren only while the system controller bit is set
// RULE7: instruments go remote only after listen address with ren asserted
// RULE8: stop during async transfer halts it and reports abort error
// RULE9: sync transfer or timeout-masked wait ends on timeout, sets flag
// RULE10: code 0 no timeout, codes 1-17 give 10us..1000s in 1,3,10 steps
// RULE11: wait completes when any masked status condition is true
// RULE12: wait mask bits match status word bit positions
// RULE13: without timeout mask bit the wait never expires
// RULE14: timeout-only mask with zero timeout returns status at once
// RULE15: device waits allow timeout_flag,end,rqs,io_complete; board waits all but rqs
// RULE16: status bits 15 error, 14 timeout, 13 end detected
// RULE17: status bits 12 srq line, 11 device request, 10 polled
// RULE18: bit 9 trigger/clear/ifc event, bit 8 io complete
// RULE19: bits 7 lockout, 6 remote, 5 in charge, 4 atn
// RULE20: bits 3 talker, 2 listener, 1 trigger, 0 device clear
// RULE21: prescaled timeout counter reloaded at start, cleared at end
// RULE22: ifc request while not system controller errors, no ifc drive
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "gpcsc_consts.vh"
module gpcsc_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        srq_in,
  input  wire        atn_in,
  input  wire        end_in,
  input  wire        lockout_in,
  input  wire        remote_in,
  input  wire        talker_in,
  input  wire        listener_in,
  input  wire        trig_in,
  input  wire        dclr_in,
  input  wire        polled_by_controller_done,
  input  wire [7:0]  polled_by_controller_byte,
  input  wire        polled_in,
  output reg         ifc_out,
  output reg         ifc_oe,
  output reg         ren_out,
  output reg         ren_oe,
  output reg         atn_out,
  output reg         atn_oe,
  output reg         srq_out,
  output reg         srq_oe,
  output reg         polled_by_controller_req,
  output reg  [4:0]  polled_by_controller_addr,
  output reg         xfer_abort
);
  localparam ST_IDLE = 3'b001;
  localparam ST_POLL = 3'b010;
  localparam ST_IFC  = 3'b100;
  localparam integer IFC_CYC_I  = `GPCSC_IFC_CYC;
  localparam integer TICK_CYC_I = `GPCSC_TICK_CYC;
  localparam [7:0]  IFC_CYC    = IFC_CYC_I[7:0];
  localparam [7:0]  TICK_CYC   = TICK_CYC_I[7:0];

  // pin synchronisers, first stage read only by second
  reg  [10:0] s1_r;
  reg  [10:0] s2_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 11'h000;
      s2_r <= 11'h000;
    end else begin
      s1_r <= {polled_in, polled_by_controller_done, dclr_in, trig_in, listener_in, talker_in,
               remote_in, lockout_in, end_in, atn_in, srq_in};
      s2_r <= s1_r;
    end
  end
  wire srq_s   = s2_r[0];
  wire atn_s   = s2_r[1];
  wire end_s   = s2_r[2];
  wire done_s  = s2_r[9];
  reg  [10:0] s3_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s3_r <= 11'h000;
    else s3_r <= s2_r;
  end
  wire done_p  = done_s & ~s3_r[9];
  wire evt_p   = (s2_r[7] & ~s3_r[7]) | (s2_r[8] & ~s3_r[8]);
  wire spl_p   = s2_r[10] & ~s3_r[10];

  // ahb-lite address phase capture
  reg        wr_pend_r;
  reg  [7:0] addr_r;
  wire       take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= take & hwrite;
      if (take) addr_r <= haddr;
    end
  end

  reg  [3:0]  cfg_r;
  reg  [4:0]  tmo_code_r;
  reg  [7:0]  stb_r;
  reg  [4:0]  sp_addr_r;
  reg  [7:0]  sp_resp_r;
  reg  [15:0] mask_r;
  reg  [3:0]  err_code_r;
  reg         err_r, timeout_flag_r, io_complete_r, rqs_r, event_r, spolled_r, cic_r;
  reg         wait_r, sync_r, async_r;
  reg  [2:0]  state_r;
  reg  [7:0]  ifc_cnt_r;
  reg  [7:0]  pre_r;
  reg  [27:0] tmo_cnt_r;
  reg  [4:0]  last_addr_r;
  reg         last_ok_r;

  wire        wr    = wr_pend_r;
  wire [7:0]  cmd   = (wr && addr_r == `GPCSC_A_CMD) ? hwdata[7:0] : 8'h00;
  wire [15:0] vmask = cfg_r[`GPCSC_F_BOARD] ? `GPCSC_BRD_MASK : `GPCSC_DEV_MASK; // RULE15
  wire [15:0] status;
  assign status = {err_r, timeout_flag_r, end_s, srq_s, rqs_r, spolled_r, event_r, io_complete_r, // RULE16 RULE17 RULE18
                   s2_r[3], s2_r[4], cic_r, atn_s | atn_out,                       // RULE19
                   s2_r[5], s2_r[6], s2_r[7], s2_r[8]};                             // RULE20
  wire [15:0] emask    = mask_r & vmask;                                           // RULE12
  wire        hit      = |(status & emask & ~(16'h1 << `GPCSC_S_TIMEOUT_FLAG));            // RULE11

  // timeout length in 10 us ticks: 1, 3, then the next decade
  function [27:0] tmo_ticks;
    input [4:0] c;
    reg   [4:0]  m;
    reg   [27:0] base;
    integer      k;
    begin
      m    = c - 5'd1;
      base = 28'h0000001;
      for (k = 0; k < 8; k = k + 1)
        if (m[4:1] > k[3:0]) base = base * 28'd10;
      tmo_ticks = m[0] ? base * 28'd3 : base;
      if (c == 5'd0 || c > 5'd17) tmo_ticks = 28'h0000000; // RULE10
    end
  endfunction

  wire start_sync  = cmd[`GPCSC_C_XFER_SYNC];
  wire start_async = cmd[`GPCSC_C_XFER_ASYNC];
  wire start_wait  = cmd[`GPCSC_C_WAIT];
  wire run_tmo     = (sync_r | (wait_r & emask[`GPCSC_S_TIMEOUT_FLAG])) & (tmo_code_r != 5'd0);
  wire tick        = (pre_r == TICK_CYC - 8'd1);
  wire expire      = run_tmo & tick & (tmo_cnt_r == 28'h0000001);              // RULE9

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= 4'h0; tmo_code_r <= 5'd0; stb_r <= 8'h00; sp_addr_r <= 5'd0;
      sp_resp_r <= 8'h00; mask_r <= 16'h0000; err_code_r <= `GPCSC_E_NONE;
      err_r <= 1'b0; timeout_flag_r <= 1'b0; io_complete_r <= 1'b0; rqs_r <= 1'b0;
      event_r <= 1'b0; spolled_r <= 1'b0; cic_r <= 1'b0;
      wait_r <= 1'b0; sync_r <= 1'b0; async_r <= 1'b0;
      state_r <= ST_IDLE; ifc_cnt_r <= 8'h00; pre_r <= 8'h00; tmo_cnt_r <= 28'h0000000;
      last_addr_r <= 5'd0; last_ok_r <= 1'b0;
      hrdata <= 32'h00000000; hreadyout <= 1'b1; hresp <= 1'b0;
      ifc_out <= 1'b0; ifc_oe <= 1'b0; ren_out <= 1'b0; ren_oe <= 1'b0;
      atn_out <= 1'b0; atn_oe <= 1'b0; srq_out <= 1'b0; srq_oe <= 1'b0;
      polled_by_controller_req <= 1'b0; polled_by_controller_addr <= 5'd0; xfer_abort <= 1'b0;
    end else begin
      xfer_abort <= 1'b0;
      if (wr) begin
        case (addr_r)
          `GPCSC_A_CFG:    cfg_r <= hwdata[3:0];
          `GPCSC_A_TMO:    tmo_code_r <= hwdata[4:0];
          `GPCSC_A_SPADDR: sp_addr_r <= hwdata[4:0];
          `GPCSC_A_MASK:   mask_r <= hwdata[15:0];
          `GPCSC_A_STB: begin
            stb_r <= hwdata[7:0];                                              // RULE3
            srq_out <= hwdata[`GPCSC_RQS_BIT];
            srq_oe  <= hwdata[`GPCSC_RQS_BIT];
          end
          default: ;
        endcase
      end
      ren_out <= cfg_r[`GPCSC_F_REN] & cfg_r[`GPCSC_F_SYSCTL];                // RULE6
      ren_oe  <= cfg_r[`GPCSC_F_REN] & cfg_r[`GPCSC_F_SYSCTL];
      if (cmd[`GPCSC_C_CLRERR]) begin
        err_r <= 1'b0; err_code_r <= `GPCSC_E_NONE; timeout_flag_r <= 1'b0;
        io_complete_r <= 1'b0; event_r <= 1'b0; spolled_r <= 1'b0;
      end
      if (evt_p) event_r <= 1'b1;       // set after clear wins
      if (spl_p) begin
        spolled_r <= 1'b1;
        srq_out <= 1'b0;
        srq_oe  <= 1'b0;
      end
      // timeout counter on 10 us prescaled ticks
      pre_r <= (tick | ~run_tmo) ? 8'h00 : pre_r + 8'h01;
      if (start_sync | start_wait) begin
        tmo_cnt_r <= tmo_ticks(tmo_code_r);                                    // RULE21
        pre_r <= 8'h00;
        timeout_flag_r <= 1'b0;
      end else if (run_tmo & tick)
        tmo_cnt_r <= tmo_cnt_r - 28'h0000001;
      if (start_sync) begin sync_r <= 1'b1; io_complete_r <= 1'b0; end
      if (start_async) begin async_r <= 1'b1; io_complete_r <= 1'b0; end
      if (start_wait) wait_r <= 1'b1;
      if ((sync_r | async_r) & (done_p | cmd[`GPCSC_C_DONE])) begin
        sync_r <= 1'b0; async_r <= 1'b0; io_complete_r <= 1'b1; tmo_cnt_r <= 28'h0000000;
      end
      if (cmd[`GPCSC_C_STOP] & async_r) begin
        async_r <= 1'b0; xfer_abort <= 1'b1; io_complete_r <= 1'b1;                   // RULE8
        err_r <= 1'b1; err_code_r <= `GPCSC_E_ABORT;
      end
      if (expire) begin
        timeout_flag_r <= 1'b1; tmo_cnt_r <= 28'h0000000;                              // RULE9
        if (sync_r) begin
          sync_r <= 1'b0; xfer_abort <= 1'b1; err_r <= 1'b1; err_code_r <= `GPCSC_E_ABORT;
        end
        if (wait_r & emask[`GPCSC_S_TIMEOUT_FLAG]) wait_r <= 1'b0;
      end
      if (wait_r & hit) wait_r <= 1'b0;                                        // RULE11 RULE13
      if (start_wait & (emask == (16'h1 << `GPCSC_S_TIMEOUT_FLAG)) & (tmo_code_r == 5'd0))
        wait_r <= 1'b0;                                                        // RULE14
      case (state_r)
        ST_IDLE: begin
          if (cmd[`GPCSC_C_IFC]) begin
            if (cfg_r[`GPCSC_F_SYSCTL]) begin
              ifc_out <= 1'b1; ifc_oe <= 1'b1; ifc_cnt_r <= IFC_CYC;          // RULE4
              state_r <= ST_IFC;
            end else begin
              err_r <= 1'b1; err_code_r <= `GPCSC_E_NOTSYSC;                   // RULE22
            end
          end else if (cmd[`GPCSC_C_POLLED_BY_CONTROLLER]) begin
            if (cfg_r[`GPCSC_F_AUTOPOLL] & last_ok_r & (last_addr_r == sp_addr_r)) begin
              rqs_r <= sp_resp_r[`GPCSC_RQS_BIT];                              // RULE2
              io_complete_r <= 1'b1;
            end else begin
              polled_by_controller_req <= 1'b1; polled_by_controller_addr <= sp_addr_r; io_complete_r <= 1'b0;
              state_r <= ST_POLL;
            end
          end
        end
        ST_POLL: begin
          if (done_p) begin
            polled_by_controller_req <= 1'b0; sp_resp_r <= polled_by_controller_byte;
            rqs_r <= polled_by_controller_byte[`GPCSC_RQS_BIT];                               // RULE1
            last_addr_r <= polled_by_controller_addr; last_ok_r <= 1'b1; io_complete_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_IFC: begin
          if (ifc_cnt_r == 8'h01) begin
            ifc_out <= 1'b0; ifc_oe <= 1'b0;
            cic_r <= 1'b1; atn_out <= 1'b1; atn_oe <= 1'b1;                    // RULE5
            event_r <= 1'b1; last_ok_r <= 1'b0; sync_r <= 1'b0; async_r <= 1'b0;
            state_r <= ST_IDLE;
          end
          ifc_cnt_r <= ifc_cnt_r - 8'h01;
        end
        default: state_r <= ST_IDLE;
      endcase
      // loaded at the address phase so it stands through the data phase
      if (take & ~hwrite) begin
        case (haddr)
          `GPCSC_A_CFG:    hrdata <= {28'h0000000, cfg_r};
          `GPCSC_A_TMO:    hrdata <= {27'h0000000, tmo_code_r};
          `GPCSC_A_STB:    hrdata <= {24'h000000, stb_r};
          `GPCSC_A_SPADDR: hrdata <= {27'h0000000, sp_addr_r};
          `GPCSC_A_SPRESP: hrdata <= {24'h000000, sp_resp_r};
          `GPCSC_A_MASK:   hrdata <= {16'h0000, mask_r};
          `GPCSC_A_STATUS: hrdata <= {13'h0000, state_r != ST_IDLE, sync_r | async_r, wait_r, status};
          `GPCSC_A_ERR:    hrdata <= {28'h0000000, err_code_r};
          default:         hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: verification/gpcsc_checker.sv
// Purpose: port-level checks of the gpib status/control core
// Assumes: bound to gpcsc_top, single hclk domain
// Notes:   two high cycles of ifc cover 100 ns at a 50 ns period
`timescale 1ns/1ns
module gpcsc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ifc_out,
  input wire logic ifc_oe,
  input wire logic atn_out,
  input wire logic atn_oe,
  input wire logic ren_out,
  input wire logic ren_oe,
  input wire logic srq_out,
  input wire logic srq_oe,
  input wire logic polled_in,
  input wire logic polled_by_controller_req,
  input wire logic polled_by_controller_done,
  input wire logic xfer_abort
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ifc_width_a: assert property ($rose(ifc_out) |-> ifc_out[*2]) else $error("ifc pulse short");
  ifc_drive_a: assert property (ifc_out |-> ifc_oe) else $error("ifc not driven");
  atn_after_a: assert property ($fell(ifc_out) |-> ##[0:1] (atn_out && atn_oe)) else $error("no atn");
  ren_drive_a: assert property (ren_out |-> ren_oe) else $error("ren not driven");
  srq_drive_a: assert property (srq_out |-> srq_oe) else $error("srq not driven");
  srq_clear_a: assert property ($rose(polled_in) |-> ##[1:5] !srq_out) else $error("srq kept");
  abort_pulse_a: assert property (xfer_abort |=> !xfer_abort) else $error("abort too long");
  poll_hold_a: assert property (polled_by_controller_req && !polled_by_controller_done |=> polled_by_controller_req) else $error("poll dropped");
endmodule
bind gpcsc_top gpcsc_checker i_gpcsc_checker (.hclk, .hresetn, .ifc_out, .ifc_oe, .atn_out, .atn_oe,
  .ren_out, .ren_oe, .srq_out, .srq_oe, .polled_in, .polled_by_controller_req, .polled_by_controller_done, .xfer_abort);

// File: verification/gpcsc_poll_model.sv
// Purpose: serial poll engine on the far side of the core
// Assumes: answers a held request after a few cycles
// Notes:   only the first poll asks for service
`timescale 1ns/1ns
module gpcsc_poll_model (
  input  wire logic       hclk,
  input  wire logic       polled_by_controller_req,
  output logic            polled_by_controller_done,
  output logic [7:0]      polled_by_controller_byte,
  output int              polls
);
  initial begin
    polled_by_controller_done = 1'b0;
    polled_by_controller_byte = 8'h00;
    polls = 0;
  end
  always @(posedge hclk) begin
    if (polled_by_controller_req && !polled_by_controller_done) begin
      repeat (3) @(posedge hclk);
      polled_by_controller_byte <= (polls == 0) ? 8'h41 : 8'h02;
      polls <= polls + 1;
      // byte settles a cycle before done
      @(posedge hclk);
      polled_by_controller_done <= 1'b1;
    end else if (!polled_by_controller_req && polled_by_controller_done) begin
      polled_by_controller_done <= 1'b0;
      // released byte must not look valid
      polled_by_controller_byte <= ~polled_by_controller_byte;
    end
  end
endmodule

// File: verification/gpcsc_top_tb.sv
// Purpose: self-checking bench of the gpib status/control core
// Assumes: zero-wait slave, hready fed back from hreadyout
// Notes:   status read at 0x1C, busy bits 16..18
`timescale 1ns/1ns
`include "gpcsc_consts.vh"
module gpcsc_top_tb;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg         polled_in = 1'b0;
  reg  [1:0]  htrans = 2'h0;
  reg  [2:0]  hsize = 3'h2;
  reg  [7:0]  haddr = 8'h00;
  reg  [8:0]  lv = 9'h000;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] r;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, polled_by_controller_done, polled_by_controller_req, xfer_abort;
  wire        ifc_out, ifc_oe, ren_out, ren_oe, atn_out, atn_oe, srq_out, srq_oe;
  wire [7:0]  polled_by_controller_byte;
  wire [4:0]  polled_by_controller_addr;
  int         polls, ifcs = 0, aborts = 0, mismatches = 0, cmp_count = 0;
  always #25 hclk = ~hclk;
  always @(posedge hclk) if (ifc_out === 1'b1) ifcs <= ifcs + 1;
  always @(posedge hclk) if (xfer_abort === 1'b1) aborts <= aborts + 1;
  gpcsc_top i_gpcsc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .srq_in(lv[0]), .atn_in(lv[1]), .end_in(lv[2]),
    .lockout_in(lv[3]), .remote_in(lv[4]), .talker_in(lv[5]), .listener_in(lv[6]), .trig_in(lv[7]),
    .dclr_in(lv[8]), .polled_by_controller_done, .polled_by_controller_byte, .polled_in, .ifc_out, .ifc_oe, .ren_out, .ren_oe,
    .atn_out, .atn_oe, .srq_out, .srq_oe, .polled_by_controller_req, .polled_by_controller_addr, .xfer_abort);
  gpcsc_poll_model i_gpcsc_poll_model (.hclk, .polled_by_controller_req, .polled_by_controller_done, .polled_by_controller_byte, .polls);
  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task ap(input [7:0] a, input w);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task rd(input [7:0] a);
    ap(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wt(input int b, input int n);
    for (int i = 0; i < n; i++) begin
      rd(`GPCSC_A_STATUS);
      if (r[b] === 1'b0) break;
    end
  endtask
  task t_bits;
    int pos [9] = '{12, 4, 13, 7, 6, 3, 2, 1, 0};
    for (int i = 0; i < 9; i++) begin
      @(posedge hclk);
      lv <= 9'h001 << i;
      repeat (4) @(posedge hclk);
      rd(`GPCSC_A_STATUS);
      chk(r & 32'h30DF, 32'h1 << pos[i]);
    end
    @(posedge hclk);
    lv <= 9'h000;
    $display("t_bits done");
  endtask
  task t_ren;
    wr(`GPCSC_A_CFG, 32'h3);
    repeat (2) @(posedge hclk);
    chk(ren_out, 1'b1);
    lv <= 9'h040;
    repeat (4) @(posedge hclk);
    lv <= 9'h050;
    repeat (4) @(posedge hclk);
    rd(`GPCSC_A_STATUS);
    chk(r[6] & r[2], 1);
    lv <= 9'h000;
    wr(`GPCSC_A_CFG, 32'h1);
    repeat (2) @(posedge hclk);
    chk(ren_out, 1'b0);
    $display("t_ren done");
  endtask
  task t_ifc;
    wr(`GPCSC_A_CFG, 32'h0);
    wr(`GPCSC_A_CMD, 32'h1);
    rd(`GPCSC_A_ERR);
    chk(r, 32'h5);
    rd(`GPCSC_A_STATUS);
    chk(r[15], 1'b1);
    chk(ifcs, 0);
    wr(`GPCSC_A_CFG, 32'h1);
    wr(`GPCSC_A_CMD, 32'h1);
    repeat (6) @(posedge hclk);
    chk(ifcs >= 2, 1);
    chk(atn_out & atn_oe, 1'b1);
    rd(`GPCSC_A_STATUS);
    chk(r & 32'h0220, 32'h0220);
    $display("t_ifc done");
  endtask
  task t_poll;
    wr(`GPCSC_A_CFG, 32'h5);
    wr(`GPCSC_A_SPADDR, 32'h3);
    wr(`GPCSC_A_CMD, 32'h2);
    wt(18, 40);
    rd(`GPCSC_A_SPRESP);
    chk(r[7:0], 8'h41);
    rd(`GPCSC_A_STATUS);
    chk({r[11], r[8]}, 2'b11);
    wr(`GPCSC_A_CMD, 32'h2);
    wt(18, 40);
    chk(polls, 1);
    rd(`GPCSC_A_SPRESP);
    chk(r[7:0], 8'h41);
    wr(`GPCSC_A_SPADDR, 32'h4);
    wr(`GPCSC_A_CMD, 32'h2);
    wt(18, 40);
    chk(polls, 2);
    chk(polled_by_controller_addr, 5'h04);
    rd(`GPCSC_A_STATUS);
    chk(r[11], 1'b0);
    $display("t_poll done");
  endtask
  task t_stb;
    wr(`GPCSC_A_STB, 32'h40);
    repeat (2) @(posedge hclk);
    chk(srq_out, 1'b1);
    polled_in <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(srq_out, 1'b0);
    polled_in <= 1'b0;
    rd(`GPCSC_A_STATUS);
    chk(r[10], 1'b1);
    $display("t_stb done");
  endtask
  task t_wait;
    wr(`GPCSC_A_TMO, 32'h0);
    wr(`GPCSC_A_MASK, 32'h4000);
    wr(`GPCSC_A_CMD, 32'h4);
    rd(`GPCSC_A_STATUS);
    chk(r[16], 1'b0);
    // listener set, but not a valid device-level mask bit
    lv <= 9'h040;
    wr(`GPCSC_A_CFG, 32'h1);
    wr(`GPCSC_A_TMO, 32'h1);
    wr(`GPCSC_A_MASK, 32'h4004);
    wr(`GPCSC_A_CMD, 32'h80);
    wr(`GPCSC_A_CMD, 32'h4);
    repeat (150) @(posedge hclk);
    rd(`GPCSC_A_STATUS);
    chk(r[16], 1'b1);
    wt(16, 150);
    chk({r[16], r[14]}, 2'b01);
    lv <= 9'h000;
    wr(`GPCSC_A_CFG, 32'h9);
    wr(`GPCSC_A_MASK, 32'h0004);
    wr(`GPCSC_A_CMD, 32'h4);
    repeat (500) @(posedge hclk);
    rd(`GPCSC_A_STATUS);
    chk(r[16], 1'b1);
    lv <= 9'h040;
    wt(16, 8);
    chk(r[16], 1'b0);
    lv <= 9'h000;
    $display("t_wait done");
  endtask
  task t_xfer;
    wr(`GPCSC_A_TMO, 32'h0);
    wr(`GPCSC_A_CMD, 32'h80);
    wr(`GPCSC_A_CMD, 32'h20);
    rd(`GPCSC_A_STATUS);
    chk(r[17], 1'b1);
    wr(`GPCSC_A_CMD, 32'h8);
    repeat (3) @(posedge hclk);
    chk(aborts, 1);
    rd(`GPCSC_A_ERR);
    chk(r, 32'h6);
    rd(`GPCSC_A_STATUS);
    chk({r[17], r[15], r[8]}, 3'b011);
    wr(`GPCSC_A_TMO, 32'h1);
    wr(`GPCSC_A_CMD, 32'h10);
    wt(17, 200);
    chk({r[17], r[14]}, 2'b01);
    chk(aborts, 2);
    wr(`GPCSC_A_TMO, 32'h0);
    wr(`GPCSC_A_CMD, 32'h10);
    rd(`GPCSC_A_STATUS);
    chk({r[17], r[8]}, 2'b10);
    wr(`GPCSC_A_CMD, 32'h40);
    rd(`GPCSC_A_STATUS);
    chk({r[17], r[8]}, 2'b01);
    $display("t_xfer done");
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_bits;
    t_ren;
    t_ifc;
    t_poll;
    t_stb;
    t_wait;
    t_xfer;
    conclude;
  end
  // whole run needs about 1200 cycles
  initial begin
    #1000000;
    mismatches++;
    conclude;
  end
endmodule
